// [src/flash_status_cfg.svh]
// flash_status_cfg.svh: status bit positions, reset value, opcodes, busy counts
// assumes: included by bare name in each design file that needs it
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH
`define STATUS_RESET 8'h00
`define BIT_BUSY 0
`define BIT_WEL 1
`define BIT_BP_LO 2
`define BIT_BP_HI 5
`define BIT_QE 6
`define BIT_LOCK 7
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_QUAD_PAGE_PROGRAM_A 8'h32
`define CMD_QUAD_PAGE_PROGRAM_B 8'h38
`define CMD_SECTOR_ERASE_A 8'hD7
`define CMD_SECTOR_ERASE_B 8'h20
`define CMD_BLOCK32_ERASE 8'h52
`define CMD_BLOCK64_ERASE 8'hD8
`define CMD_CHIP_ERASE_A 8'hC7
`define CMD_CHIP_ERASE_B 8'h60
`define CMD_STATUS_WRITE 8'h01
`define CMD_FUNCTION_REG_WRITE 8'h42
`define CMD_NV_READ_PARAM_SET 8'h65
`define CMD_NV_EXT_READ_PARAM_SET 8'h85
`define CMD_INFO_ROW_ERASE 8'h64
`define CMD_INFO_ROW_PROGRAM 8'h62
`define CMD_AUTOBOOT_WRITE 8'h15
`define CMD_V_READ_PARAM_SET_A 8'hC0
`define CMD_V_READ_PARAM_SET_B 8'h63
`define CMD_V_EXT_READ_PARAM_SET 8'h83
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_FUNCTION_REG_READ 8'h48
`define CMD_EXT_READ_PARAM_READ 8'h81
`define CMD_RESET_ENABLE 8'h66
`define CMD_RESET 8'h99
`define CMD_SUSPEND_A 8'h75
`define CMD_SUSPEND_B 8'hB0
`define CMD_RESUME_A 8'h7A
`define CMD_RESUME_B 8'h30
`define ADDR_BYTES 3
`define PROGRAM_BUSY_CYCLES 400
`define ERASE_BUSY_CYCLES 2000
`define NV_BUSY_CYCLES 800
`endif

// [src/flash_status_pkg.sv]
// flash_status_pkg: types shared by the status and write-permission logic
// assumes: compiled before every other design file
`default_nettype none
package flash_status_pkg;
   typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_READ, ST_SKIP} frame_state_type;
   typedef enum logic [1:0] {OPK_NONE, OPK_PROGRAM, OPK_ERASE, OPK_NVREG} op_kind_type;
endpackage
`default_nettype wire

// [src/spi_byte_if.sv]
// spi_byte_if: byte-level link between the serial port and the command core
// assumes: both ends run on ref_clk; pulses last one ref_clk cycle
`default_nettype none
interface spi_byte_if;
   logic byte_valid;
   logic [7:0] rx_byte;
   logic frame_start;
   logic frame_end;
   logic [7:0] tx_byte;
   logic tx_drive;
   modport port (output byte_valid, rx_byte, frame_start, frame_end, input tx_byte, tx_drive);
   modport core (input byte_valid, rx_byte, frame_start, frame_end, output tx_byte, tx_drive);
endinterface
`default_nettype wire

// [src/spi_serial_port.sv]
// spi_serial_port: oversampled spi mode 0/3 slave, msb first, byte framing
// assumes: ref_clk at least 8x faster than spi_sck; pins are asynchronous
`default_nettype none
module spi_serial_port (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // pins
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe,
   // byte side
   spi_byte_if.port bus
);
   logic [2:0] sck_meta_r, sck_sync_r, sck_old_r;
   logic [2:0] pin_nxt;
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_sh_r, tx_sh_r;
   logic sck_rise, sck_fall, cs_low;
   assign pin_nxt = {spi_sck, spi_cs_n, spi_si};
   // two flops before any logic; the edge finder reads the second and its delayed copy
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_meta_r <= 3'h2;
         sck_sync_r <= 3'h2;
         sck_old_r <= 3'h2;
      end else begin
         sck_meta_r <= pin_nxt;
         sck_sync_r <= sck_meta_r;
         sck_old_r <= sck_sync_r;
      end
   end
   assign cs_low = !sck_sync_r[1];
   assign sck_rise = cs_low && sck_sync_r[2] && !sck_old_r[2];
   assign sck_fall = cs_low && !sck_sync_r[2] && sck_old_r[2];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.frame_start <= 1'b0;
         bus.frame_end <= 1'b0;
      end else begin
         bus.frame_start <= !sck_sync_r[1] && sck_old_r[1];
         bus.frame_end <= sck_sync_r[1] && !sck_old_r[1];
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_r <= 3'h0;
         rx_sh_r <= 8'h00;
         bus.rx_byte <= 8'h00;
         bus.byte_valid <= 1'b0;
      end else begin
         bus.byte_valid <= 1'b0;
         if (!cs_low) begin
            bit_cnt_r <= 3'h0;
         end else if (sck_rise) begin
            rx_sh_r <= {rx_sh_r[6:0], sck_sync_r[0]};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
               bus.rx_byte <= {rx_sh_r[6:0], sck_sync_r[0]};
               bus.byte_valid <= 1'b1;
            end
         end
      end
   end
   // a new byte is loaded on the falling edge with the bit count at zero: last of the previous slot in mode 0, first of the slot in mode 3
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_r <= 8'h00;
      end else if (sck_fall) begin
         if (bit_cnt_r == 3'h0) begin
            tx_sh_r <= bus.tx_byte;
         end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         spi_so <= 1'b0;
         spi_so_oe <= 1'b0;
      end else begin
         spi_so <= tx_sh_r[7];
         spi_so_oe <= bus.tx_drive && cs_low;
      end
   end
endmodule // spi_serial_port
`default_nettype wire

// [src/protect_check.sv]
// protect_check: decodes the block-protect field into a hit for one block
// assumes: block index is the top address bits of a 64 KB block
`default_nettype none
module protect_check #(
   parameter int BLOCK_BITS = 4
) (
   // protect field and target
   input wire logic [3:0] block_protect,
   input wire logic [BLOCK_BITS-1:0] block_index,
   // result
   output logic hit
);
   // smaller maps saturate to all blocks earlier; below two bits it is meaningless
   initial begin
      if (BLOCK_BITS < 2 || BLOCK_BITS > 4) begin
         $error("protect_check: BLOCK_BITS must be 2 to 4");
      end
   end
   localparam int NBLK = 1 << BLOCK_BITS;
   always_comb begin
      int sh;
      int idx;
      sh = 0;
      idx = int'(block_index);
      if (block_protect == 4'h0 || block_protect == 4'hF) begin
         hit = 1'b0;
      end else if (!block_protect[3]) begin
         sh = int'(block_protect) - 1;
         hit = (sh >= BLOCK_BITS) || (idx >= NBLK - (1 << sh));
      end else begin
         sh = 14 - int'(block_protect);
         hit = (sh >= BLOCK_BITS) || (idx < (1 << sh));
      end
   end
endmodule // protect_check
`default_nettype wire

// [src/flash_status_write_protect.sv]
// flash_status_write_protect: status register, busy and write-permission logic
// assumes: a host spi controller on the pins; array operations are timed only
`default_nettype none
`include "flash_status_cfg.svh"
module flash_status_write_protect
   import flash_status_pkg::*;
#(
   parameter int PROGRAM_CYCLES = `PROGRAM_BUSY_CYCLES,
   parameter int ERASE_CYCLES = `ERASE_BUSY_CYCLES,
   parameter int NV_CYCLES = `NV_BUSY_CYCLES,
   parameter int BLOCK_BITS = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // serial pins
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe,
   // write protect pin
   input wire logic wp_n,
   // status and pin function
   output logic [7:0] status_flags,
   output logic quad_io_mode,
   output logic wp_pin_active,
   output logic hold_pin_active
);
   initial begin
      if (PROGRAM_CYCLES < 1 || ERASE_CYCLES < 1 || NV_CYCLES < 1 ||
          PROGRAM_CYCLES > 65535 || ERASE_CYCLES > 65535 || NV_CYCLES > 65535) begin
         $error("flash_status_write_protect: busy counts must be 1 to 65535");
      end
   end
   spi_byte_if bus ();
   spi_serial_port u_port (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n),
      .spi_si(spi_si),
      .spi_so(spi_so),
      .spi_so_oe(spi_so_oe),
      .bus(bus.port)
   );
   frame_state_type state_r;
   op_kind_type kind_r, kind_nxt;
   logic [1:0] byte_cnt_r;
   logic [7:0] opcode_r, data_r;
   logic [23:0] addr_r;
   logic opcode_seen_r, addr_done_r, have_data_r;
   logic busy_r, suspended_r, wel_r, reset_armed_r;
   logic [5:0] nv_r;
   logic [15:0] timer_r, timer_nxt;
   logic wp_meta_r, wp_sync_r;
   logic [7:0] tx_byte_r;
   logic tx_drive_r;
   logic prot_hit, lock, exec, acc, done;
   logic start_prog, start_erase, start_sw, start_nv, start_any;
   logic do_suspend, do_resume, do_reset;
   logic [3:0] bp;
   function automatic logic is_program(input logic [7:0] op);
      return op == `CMD_PAGE_PROGRAM || op == `CMD_QUAD_PAGE_PROGRAM_A ||
             op == `CMD_QUAD_PAGE_PROGRAM_B;
   endfunction
   function automatic logic is_erase(input logic [7:0] op);
      return op == `CMD_SECTOR_ERASE_A || op == `CMD_SECTOR_ERASE_B ||
             op == `CMD_BLOCK32_ERASE || op == `CMD_BLOCK64_ERASE;
   endfunction
   function automatic logic is_chip(input logic [7:0] op);
      return op == `CMD_CHIP_ERASE_A || op == `CMD_CHIP_ERASE_B;
   endfunction
   function automatic logic is_nvreg(input logic [7:0] op);
      return op == `CMD_FUNCTION_REG_WRITE || op == `CMD_NV_READ_PARAM_SET ||
             op == `CMD_NV_EXT_READ_PARAM_SET || op == `CMD_INFO_ROW_ERASE ||
             op == `CMD_INFO_ROW_PROGRAM || op == `CMD_AUTOBOOT_WRITE;
   endfunction
   function automatic logic is_suspend(input logic [7:0] op);
      return op == `CMD_SUSPEND_A || op == `CMD_SUSPEND_B;
   endfunction
   function automatic logic is_resume(input logic [7:0] op);
      return op == `CMD_RESUME_A || op == `CMD_RESUME_B;
   endfunction
   function automatic logic busy_ok(input logic [7:0] op);
      return op == `CMD_STATUS_READ || op == `CMD_FUNCTION_REG_READ ||
             op == `CMD_EXT_READ_PARAM_READ || op == `CMD_RESET_ENABLE ||
             op == `CMD_RESET || is_suspend(op);
   endfunction
   function automatic logic needs_addr(input logic [7:0] op);
      return is_program(op) || is_erase(op) || op == `CMD_INFO_ROW_ERASE ||
             op == `CMD_INFO_ROW_PROGRAM;
   endfunction
   assign bp = nv_r[`BIT_BP_HI-2:`BIT_BP_LO-2];
   protect_check #(
      .BLOCK_BITS(BLOCK_BITS)
   ) u_protect (
      .block_protect(bp),
      .block_index(addr_r[16+BLOCK_BITS-1:16]),
      .hit(prot_hit)
   );
   // the pin is only a protect input while quad mode is off
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_meta_r <= 1'b1;
         wp_sync_r <= 1'b1;
      end else begin
         wp_meta_r <= wp_n;
         wp_sync_r <= wp_meta_r;
      end
   end
   assign lock = nv_r[`BIT_LOCK-2] && !nv_r[`BIT_QE-2] && !wp_sync_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_SKIP;
         byte_cnt_r <= 2'h0;
      end else if (bus.frame_start) begin
         state_r <= ST_OPCODE;
         byte_cnt_r <= 2'h0;
      end else if (bus.byte_valid) begin
         case (state_r)
            ST_OPCODE: begin
               if (busy_r && !busy_ok(bus.rx_byte)) begin
                  state_r <= ST_SKIP;
               end else if (bus.rx_byte == `CMD_STATUS_READ) begin
                  state_r <= ST_READ;
               end else if (needs_addr(bus.rx_byte)) begin
                  state_r <= ST_ADDR;
               end else if (bus.rx_byte == `CMD_STATUS_WRITE) begin
                  state_r <= ST_DATA;
               end else begin
                  state_r <= ST_SKIP;
               end
            end
            ST_ADDR: begin
               byte_cnt_r <= byte_cnt_r + 2'h1;
               if (byte_cnt_r == 2'(`ADDR_BYTES - 1)) begin
                  state_r <= ST_SKIP;
               end
            end
            ST_DATA: state_r <= ST_SKIP;
            ST_READ: state_r <= ST_READ;
            default: state_r <= ST_SKIP;
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         opcode_r <= 8'h00;
         addr_r <= 24'h000000;
         data_r <= 8'h00;
         opcode_seen_r <= 1'b0;
         addr_done_r <= 1'b0;
         have_data_r <= 1'b0;
      end else if (bus.frame_start) begin
         opcode_seen_r <= 1'b0;
         addr_done_r <= 1'b0;
         have_data_r <= 1'b0;
      end else if (bus.byte_valid) begin
         case (state_r)
            ST_OPCODE: begin
               opcode_r <= bus.rx_byte;
               opcode_seen_r <= !(busy_r && !busy_ok(bus.rx_byte));
            end
            ST_ADDR: begin
               addr_r <= {addr_r[15:0], bus.rx_byte};
               addr_done_r <= byte_cnt_r == 2'(`ADDR_BYTES - 1);
            end
            ST_DATA: begin
               data_r <= bus.rx_byte;
               have_data_r <= 1'b1;
            end
            default: have_data_r <= have_data_r;
         endcase
      end
   end
   // commands act when chip select rises
   assign exec = bus.frame_end && opcode_seen_r;
   assign acc = exec && !busy_r && !suspended_r;
   assign done = busy_r && !suspended_r && timer_r == 16'h0000;
   assign start_prog = acc && is_program(opcode_r) && wel_r && addr_done_r && !prot_hit;
   assign start_erase = acc && addr_done_r && is_erase(opcode_r) && wel_r && !prot_hit;
   assign start_sw = acc && opcode_r == `CMD_STATUS_WRITE && wel_r && have_data_r && !lock;
   assign start_nv = acc && is_nvreg(opcode_r) && wel_r && (addr_done_r || !needs_addr(opcode_r));
   assign start_any = start_prog || start_erase || start_sw || start_nv ||
                      (acc && is_chip(opcode_r) && wel_r && bp == 4'h0);
   assign do_suspend = exec && busy_r && is_suspend(opcode_r) &&
                       (kind_r == OPK_PROGRAM || kind_r == OPK_ERASE);
   assign do_resume = exec && !busy_r && suspended_r && is_resume(opcode_r);
   assign do_reset = exec && reset_armed_r && opcode_r == `CMD_RESET;
   always_comb begin
      kind_nxt = OPK_ERASE;
      timer_nxt = 16'(ERASE_CYCLES - 1);
      if (start_prog) begin
         kind_nxt = OPK_PROGRAM;
         timer_nxt = 16'(PROGRAM_CYCLES - 1);
      end else if (start_sw || start_nv) begin
         kind_nxt = OPK_NVREG;
         timer_nxt = 16'(NV_CYCLES - 1);
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_armed_r <= 1'b0;
      end else if (exec) begin
         reset_armed_r <= opcode_r == `CMD_RESET_ENABLE;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         suspended_r <= 1'b0;
         timer_r <= 16'h0000;
         kind_r <= OPK_NONE;
      end else if (do_reset) begin
         busy_r <= 1'b0;
         suspended_r <= 1'b0;
         kind_r <= OPK_NONE;
      end else if (do_suspend) begin
         busy_r <= 1'b0;
         suspended_r <= 1'b1;
      end else if (do_resume) begin
         busy_r <= 1'b1;
         suspended_r <= 1'b0;
      end else if (start_any) begin
         busy_r <= 1'b1;
         timer_r <= timer_nxt;
         kind_r <= kind_nxt;
      end else if (done) begin
         busy_r <= 1'b0;
         kind_r <= OPK_NONE;
      end else if (busy_r && !suspended_r) begin
         timer_r <= timer_r - 16'h0001;
      end
   end
   // disable while busy is ignored like any other instruction outside the busy-allowed set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wel_r <= 1'b0;
      end else if (do_reset || done) begin
         wel_r <= 1'b0;
      end else if (acc && opcode_r == `CMD_WRITE_ENABLE) begin
         wel_r <= 1'b1;
      end else if (acc && opcode_r == `CMD_WRITE_DISABLE) begin
         wel_r <= 1'b0;
      end
   end
   // volatile parameter sets are accepted without the latch and leave it alone
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_r <= 6'(`STATUS_RESET >> 2);
      end else if (start_sw) begin
         nv_r <= data_r[7:2];
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_drive_r <= 1'b0;
         tx_byte_r <= `STATUS_RESET;
      end else begin
         tx_byte_r <= {nv_r, wel_r, busy_r};
         if (bus.frame_start || bus.frame_end) begin
            tx_drive_r <= 1'b0;
         end else if (bus.byte_valid && state_r == ST_OPCODE) begin
            tx_drive_r <= bus.rx_byte == `CMD_STATUS_READ;
         end
      end
   end
   assign bus.tx_byte = tx_byte_r;
   assign bus.tx_drive = tx_drive_r;
   assign status_flags = {nv_r, wel_r, busy_r};
   assign quad_io_mode = nv_r[`BIT_QE-2];
   assign wp_pin_active = !nv_r[`BIT_QE-2];
   assign hold_pin_active = !nv_r[`BIT_QE-2];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_wel_zero_cmd;
      acc && !wel_r;
   endsequence
   sequence s_busy_hold;
      busy_r [*4];
   endsequence
   chk_busy_ignore: assert property (busy_r && exec && opcode_r == `CMD_WRITE_DISABLE && !done
      |=> $stable(wel_r)) else $error("disable taken while busy");
   chk_suspend_take: assert property (do_suspend |=> !busy_r && suspended_r && status_flags[0] == 1'b0)
      else $error("suspend not taken");
   chk_done_clear: assert property (done && !exec |=> !busy_r && !wel_r)
      else $error("completion did not clear busy and latch");
   chk_enable_set: assert property (acc && opcode_r == `CMD_WRITE_ENABLE |=> status_flags[1])
      else $error("enable did not set latch");
   chk_prog_gate: assert property (s_wel_zero_cmd ##0 is_program(opcode_r) |=> !busy_r)
      else $error("program ran without latch");
   chk_erase_gate: assert property (s_wel_zero_cmd ##0 (is_erase(opcode_r) || is_chip(opcode_r))
      |=> !busy_r) else $error("erase ran without latch");
   chk_nv_gate: assert property (s_wel_zero_cmd ##0 (is_nvreg(opcode_r) ||
      opcode_r == `CMD_STATUS_WRITE) |=> !busy_r && $stable(nv_r))
      else $error("register write ran without latch");
   chk_chip_bp: assert property (acc && is_chip(opcode_r) && bp != 4'h0 |=> !busy_r)
      else $error("chip erase ran with protect set");
   chk_prot_hit: assert property (acc && is_program(opcode_r) && prot_hit |=> !busy_r)
      else $error("program ran into protected block");
   chk_lock_hold: assert property (acc && opcode_r == `CMD_STATUS_WRITE && lock
      |=> $stable(nv_r) && !busy_r) else $error("locked status changed");
   chk_status_wr: assert property (start_sw |=> nv_r == $past(data_r[7:2]) ##0 s_busy_hold)
      else $error("status write not stored or busy short");
   chk_read_load: assert property (bus.byte_valid && state_r == ST_OPCODE &&
      bus.rx_byte == `CMD_STATUS_READ |=> tx_drive_r ##1 tx_byte_r == $past(status_flags))
      else $error("status read not driven");
endmodule // flash_status_write_protect
`default_nettype wire

// [bench/spi_host_model.sv]
// spi_host_model: host controller on the serial pins, mode 0, msb first
// assumes: stepped from ref_clk rising edges; sck stands low between frames
`default_nettype none
module spi_host_model (
   // clock
   input wire logic ref_clk,
   // pins
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   input wire logic spi_so,
   // status byte seen in a read frame
   output logic rd_valid,
   output logic [7:0] rd_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
      rd_valid = 1'b0;
      rd_byte = 8'h00;
   end
   // sends n whole bytes from the top of d; half sck period is 8 ref_clk (80 ns link)
   task automatic frame(input logic [31:0] d, input int n);
      logic [7:0] r;
      r = 8'h00;
      @(posedge ref_clk) spi_cs_n <= 1'b0;
      for (int i = 0; i < n * 8; i++) begin
         spi_si <= d[31 - i];
         repeat (8) @(posedge ref_clk);
         spi_sck <= 1'b1;
         r = {r[6:0], spi_so};
         repeat (8) @(posedge ref_clk);
         spi_sck <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      spi_cs_n <= 1'b1;
      // a released data line must not keep showing the last bit
      spi_si <= ~spi_si;
      if (n == 2 && d[31:24] == 8'h05) begin
         rd_byte <= r;
         rd_valid <= 1'b1;
         @(posedge ref_clk) rd_valid <= 1'b0;
      end
      repeat (20) @(posedge ref_clk);
   endtask
endmodule // spi_host_model
`default_nettype wire

// [bench/flash_status_write_protect_tb_top.sv]
// flash_status_write_protect_tb_top: self-checking bench for the status logic
// assumes: spi_host_model drives the pins; erase and nv busy counts shortened, program count lengthened by parameter
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module flash_status_write_protect_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   logic spi_sck, spi_cs_n, spi_si, spi_so, rd_valid, quad_io_mode, wp_pin_active;
   logic spi_so_oe, hold_pin_active;
   logic [7:0] rd_byte, status_flags;
   logic [31:0] seed = 32'hFF4903BE;
   logic [7:0] expq[$];
   logic [7:0] ops[16] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7,
      8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #2.5 ref_clk = ~ref_clk;
   spi_host_model host (.ref_clk(ref_clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .spi_so(spi_so), .rd_valid(rd_valid), .rd_byte(rd_byte));
   // busy counts kept above one read frame so a read can land inside busy
   flash_status_write_protect #(.PROGRAM_CYCLES(1500), .ERASE_CYCLES(1500),
      .NV_CYCLES(600), .BLOCK_BITS(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
      .spi_so_oe(spi_so_oe), .wp_n(wp_n), .status_flags(status_flags),
      .quad_io_mode(quad_io_mode), .wp_pin_active(wp_pin_active),
      .hold_pin_active(hold_pin_active));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rd(input logic [7:0] e);
      expq.push_back(e);
      host.frame({8'h05, 24'h0}, 2);
   endtask
   task automatic wsr(input logic [7:0] v);
      host.frame({8'h06, 24'h0}, 1);
      host.frame({8'h01, v, 16'h0}, 2);
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      while (status_flags[0] !== 1'b0 && k < 4000) begin
         @(posedge ref_clk);
         k++;
      end
   endtask
   // each status byte read by the host is matched against the oldest note
   always @(posedge ref_clk) begin
      logic [7:0] e;
      if (rd_valid) begin
         e = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
         `CHK(rd_byte, e)
         // the output enable drops only a few clocks after chip select rises
         `CHK(spi_so_oe, 1'b1)
      end
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t run too long", $time);
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rd(8'h00);
      foreach (ops[i]) host.frame({ops[i], 24'h0}, 4);
      rd(8'h00);
      host.frame({8'h06, 24'h0}, 1);
      rd(8'h02);
      host.frame({8'h04, 24'h0}, 1);
      rd(8'h00);
      $display("test 1 ended");
      seed = lfsr(seed);
      // low two data bits are random: the latch and busy must not follow them
      wsr({2'b00, 4'b0001, seed[1:0]});
      rd(8'h07);
      wait_idle();
      rd(8'h04);
      $display("test 2 ended");
      host.frame({8'h06, 24'h0}, 1);
      host.frame({8'hC7, 24'h0}, 1);
      rd(8'h06);
      host.frame({8'h02, 24'h0F0000}, 4);
      rd(8'h06);
      seed = lfsr(seed);
      // block 15 is protected here, so the random address stays in blocks 0 to 7
      host.frame({8'h02, 4'h0, 1'b0, seed[18:0]}, 4);
      rd(8'h07);
      host.frame({8'h04, 24'h0}, 1);
      rd(8'h07);
      wait_idle();
      rd(8'h04);
      $display("test 3 ended");
      host.frame({8'h06, 24'h0}, 1);
      host.frame({8'h20, 4'h1, 1'b0, seed[30:12]}, 4);
      rd(8'h07);
      host.frame({8'h75, 24'h0}, 1);
      rd(8'h06);
      host.frame({8'h30, 24'h0}, 1);
      wait_idle();
      rd(8'h04);
      $display("test 4 ended");
      wsr(8'h80);
      wait_idle();
      rd(8'h80);
      wp_n <= 1'b0;
      seed = lfsr(seed);
      wsr({6'b001111, seed[1:0]});
      rd(8'h82);
      wp_n <= 1'b1;
      wsr(8'h40);
      wait_idle();
      rd(8'h40);
      `CHK(quad_io_mode, 1'b1)
      `CHK(wp_pin_active, 1'b0)
      `CHK(hold_pin_active, 1'b0)
      $display("test 5 ended");
      host.frame({8'h06, 24'h0}, 1);
      host.frame({8'h02, 24'h000000}, 4);
      rd(8'h43);
      host.frame({8'h66, 24'h0}, 1);
      host.frame({8'h99, 24'h0}, 1);
      rd(8'h40);
      host.frame({8'hC0, 8'h00, 16'h0}, 2);
      rd(8'h40);
      $display("test 6 ended");
      end_of_test();
   end
endmodule // flash_status_write_protect_tb_top
`default_nettype wire
